// file: core/ris_pkg.sv
// Purpose: Shared constants and types for the reference input selector
// Assumes: AXI4-Lite register access, 32-bit data, one aligned word per register
// Notes:   Inputs 4 and 5 are the internal loopbacks

package ris_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int unsigned NUM_IN  = 6;
   localparam int unsigned PRIO_W  = 3;
   localparam int unsigned VTIM_W  = 16;
   localparam int unsigned ADDR_W  = 8;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS  = 8'h00;
   localparam logic [7:0] PRIO1_OFS = 8'h04;
   localparam logic [7:0] PRIO2_OFS = 8'h08;
   localparam logic [7:0] MON_OFS   = 8'h0C;
   localparam logic [7:0] VTIM_OFS  = 8'h10;
   localparam logic [7:0] STAT_OFS  = 8'h14;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
   localparam logic [31:0] PRIO_RST  = 32'h0000_0000;
   localparam logic [31:0] MON_RST   = 32'h0000_0000;
   localparam logic [31:0] VTIM_RST  = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int unsigned CH_STRIDE  = 8;
   localparam int unsigned F_MODE     = 0;
   localparam int unsigned F_MANSRC   = 2;
   localparam int unsigned F_MANREG   = 3;
   localparam int unsigned F_HITLESS  = 6;
   localparam int unsigned M_XOTHR    = 0;
   localparam int unsigned M_XOFBYP   = 2;
   localparam int unsigned M_XOBYP    = 3;
   localparam int unsigned M_TCEDGE   = 4;
   localparam int unsigned M_TCFBYP   = 6;
   localparam int unsigned M_TCBYP    = 7;
   localparam int unsigned ST_STRIDE  = 8;
   localparam int unsigned ST_VALID   = 16;
   localparam int unsigned ST_XO      = 24;
   localparam int unsigned ST_TC      = 28;

   // ----------------------------------------------------------------
   // Encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] MODE_AUTO_REV  = 2'h0;
   localparam logic [1:0] MODE_AUTO_NREV = 2'h1;
   localparam logic [1:0] MODE_MAN_FB    = 2'h2;
   localparam logic [1:0] MODE_MAN_HO    = 2'h3;
   localparam logic [1:0] XOTHR_400      = 2'h0;
   localparam logic [1:0] XOTHR_600      = 2'h1;
   localparam logic [1:0] EDGE_RISE      = 2'h1;
   localparam logic [1:0] EDGE_FALL      = 2'h2;
   localparam logic [1:0] EDGE_BOTH      = 2'h3;
   localparam logic [5:0] CH1_MASK       = 6'h2F;
   localparam logic [5:0] CH2_MASK       = 6'h1F;
   localparam logic [1:0] RESP_OKAY      = 2'h0;
   localparam logic [1:0] RESP_SLVERR    = 2'h2;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      RIS_LOCKED   = 3'b001,
      RIS_HOLDOVER = 3'b010,
      RIS_FREERUN  = 3'b100
   } ris_chmode_t;

   typedef struct packed {
      logic [2:0]  sel;
      ris_chmode_t mode;
      logic        switched;
      logic        hitlessStep;
   } ris_chstat_t;

   typedef struct packed {
      logic       found;
      logic [2:0] idx;
   } ris_pick_t;

   typedef struct packed {
      logic [31:0]                          ctrl;
      logic [31:0]                          prio1;
      logic [31:0]                          prio2;
      logic [31:0]                          mon;
      logic [31:0]                          vtim;
      logic                                 awready;
      logic                                 wready;
      logic                                 awHeld;
      logic [ADDR_W-1:0]                    awAddr;
      logic                                 wHeld;
      logic [31:0]                          wData;
      logic [3:0]                           wStrb;
      logic                                 bvalid;
      logic [1:0]                           bresp;
      logic                                 arready;
      logic                                 rvalid;
      logic [31:0]                          rdata;
      logic [1:0]                           rresp;
      logic [NUM_IN-1:0][VTIM_W-1:0]        cnt;
      logic [NUM_IN-1:0]                    valid;
      logic                                 xoAmpFlag;
      logic                                 xoFreqFlag;
      logic                                 xoLos;
      logic                                 xoValid;
      logic                                 tcAmpFlag;
      logic                                 tcFreqFlag;
      logic                                 tcLos;
      logic                                 tcValid;
      ris_chstat_t [1:0]                    ch;
   } ris_state_t;

endpackage : ris_pkg

// file: core/ris_reference_input_selector.sv
// Purpose: Reference input selection for two channels, XO and TCXO qualification
// Assumes: Analog detector results arrive as synchronous level inputs
// Notes:   Index 0 of channel arrays is channel 1

`timescale 1ns/1ns

module ris_reference_input_selector (
   input  wire logic                          ref_clk,
   input  wire logic                          rst_n,
   input  wire logic [ris_pkg::ADDR_W-1:0]    s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [ris_pkg::ADDR_W-1:0]    s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [31:0]                        s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   input  wire logic [ris_pkg::NUM_IN-1:0]    refMonFlag,
   input  wire logic [1:0][1:0]               inputChoicePins,
   input  wire logic [1:0]                    historyValid,
   input  wire logic [2:0]                    xoSwingAbove,
   input  wire logic                          xoFreqInWindow,
   input  wire logic                          tcxoRiseFast,
   input  wire logic                          tcxoFallFast,
   input  wire logic                          tcxoFreqInWindow,
   output ris_pkg::ris_chstat_t               ch1Status,
   output ris_pkg::ris_chstat_t               ch2Status,
   output logic                               xoSignalLossFlag,
   output logic                               tcxoSignalLossFlag,
   output logic                               xoValid,
   output logic                               tcxoValid
);

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction : wmerge

   function automatic logic inOk(input logic [5:0] vec, input logic [2:0] idx);
      logic r;
      r = 1'b0;
      for (int i = 0; i < 6; i++) begin
         if (idx == 3'(i)) begin
            r = vec[i];
         end
      end
      return r;
   endfunction : inOk

   function automatic logic [2:0] prioOf(input logic [17:0] prio, input logic [2:0] idx);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 0; i < 6; i++) begin
         if (idx == 3'(i)) begin
            r = prio[i*3 +: 3];
         end
      end
      return r;
   endfunction : prioOf

   function automatic ris_pkg::ris_pick_t bestValid(input logic [5:0] ok,
                                                    input logic [17:0] prio);
      ris_pkg::ris_pick_t r;
      r = '0;
      // Later hits overwrite: best priority, then lowest index, wins
      for (int p = 6; p >= 1; p--) begin
         for (int i = 5; i >= 0; i--) begin
            if (ok[i] && prio[i*3 +: 3] == 3'(p)) begin
               r.found = 1'b1;
               r.idx   = 3'(i);
            end
         end
      end
      return r;
   endfunction : bestValid

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   ris_pkg::ris_state_t s_q;
   ris_pkg::ris_state_t s_d;
   ris_pkg::ris_pick_t  best [2];
   logic [5:0]          chMask [2];
   logic [17:0]         chPrio [2];
   logic [2:0]          manIdx [2];
   logic [1:0]          chMode [2];

   assign chMask[0] = ris_pkg::CH1_MASK;
   assign chMask[1] = ris_pkg::CH2_MASK;
   assign chPrio[0] = s_q.prio1[17:0];
   assign chPrio[1] = s_q.prio2[17:0];

   for (genvar c = 0; c < 2; c++) begin : g_ch
      localparam int unsigned B = c * ris_pkg::CH_STRIDE;
      assign chMode[c] = s_q.ctrl[B+ris_pkg::F_MODE +: 2];
      // Pins when source bit set, else register code
      assign manIdx[c] = s_q.ctrl[B+ris_pkg::F_MANSRC] ? {1'b0, inputChoicePins[c]}
                                                       : s_q.ctrl[B+ris_pkg::F_MANREG +: 3];
      assign best[c] = bestValid(s_q.valid & chMask[c], chPrio[c]);
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic       manOk;
      logic       curOk;
      logic       tgtFound;
      logic [2:0] tgt;
      manOk    = 1'b0;
      curOk    = 1'b0;
      tgtFound = 1'b0;
      tgt      = 3'h0;
      s_d      = s_q;

      // Write channel
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      if (s_q.awready && s_axi_awvalid) begin
         s_d.awHeld = 1'b1;
         s_d.awAddr = s_axi_awaddr;
      end
      if (s_q.wready && s_axi_wvalid) begin
         s_d.wHeld = 1'b1;
         s_d.wData = s_axi_wdata;
         s_d.wStrb = s_axi_wstrb;
      end
      if (s_q.awHeld && s_q.wHeld && !s_q.bvalid) begin
         s_d.awHeld = 1'b0;
         s_d.wHeld  = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp  = ris_pkg::RESP_OKAY;
         case (s_q.awAddr)
            ris_pkg::CTRL_OFS:  s_d.ctrl  = wmerge(s_q.ctrl,  s_q.wData, s_q.wStrb);
            ris_pkg::PRIO1_OFS: s_d.prio1 = wmerge(s_q.prio1, s_q.wData, s_q.wStrb);
            ris_pkg::PRIO2_OFS: s_d.prio2 = wmerge(s_q.prio2, s_q.wData, s_q.wStrb);
            ris_pkg::MON_OFS:   s_d.mon   = wmerge(s_q.mon,   s_q.wData, s_q.wStrb);
            ris_pkg::VTIM_OFS:  s_d.vtim  = wmerge(s_q.vtim,  s_q.wData, s_q.wStrb);
            default:            s_d.bresp = ris_pkg::RESP_SLVERR;
         endcase
      end
      s_d.ctrl[31:15]  = '0;
      s_d.ctrl[7]      = 1'b0;
      s_d.prio1[31:18] = '0;
      s_d.prio2[31:18] = '0;
      s_d.mon[31:8]    = '0;
      s_d.vtim[31:16]  = '0;
      s_d.awready      = !s_d.awHeld;
      s_d.wready       = !s_d.wHeld;

      // Read channel
      if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      if (s_q.arready && s_axi_arvalid) begin
         s_d.rvalid = 1'b1;
         s_d.rresp  = ris_pkg::RESP_OKAY;
         case (s_axi_araddr)
            ris_pkg::CTRL_OFS:  s_d.rdata = s_q.ctrl;
            ris_pkg::PRIO1_OFS: s_d.rdata = s_q.prio1;
            ris_pkg::PRIO2_OFS: s_d.rdata = s_q.prio2;
            ris_pkg::MON_OFS:   s_d.rdata = s_q.mon;
            ris_pkg::VTIM_OFS:  s_d.rdata = s_q.vtim;
            ris_pkg::STAT_OFS: begin
               s_d.rdata = '0;
               for (int c = 0; c < 2; c++) begin
                  s_d.rdata[c*ris_pkg::ST_STRIDE +: 6] = {s_q.ch[c].mode, s_q.ch[c].sel};
               end
               s_d.rdata[ris_pkg::ST_VALID +: 6] = s_q.valid;
               s_d.rdata[ris_pkg::ST_XO +: 4] = {s_q.xoValid, s_q.xoLos,
                                                 s_q.xoFreqFlag, s_q.xoAmpFlag};
               s_d.rdata[ris_pkg::ST_TC +: 4] = {s_q.tcValid, s_q.tcLos,
                                                 s_q.tcFreqFlag, s_q.tcAmpFlag};
            end
            default: begin
               s_d.rdata = '0;
               s_d.rresp = ris_pkg::RESP_SLVERR;
            end
         endcase
      end
      s_d.arready = !s_d.rvalid;

      // XO monitors
      case (s_q.mon[ris_pkg::M_XOTHR +: 2])
         ris_pkg::XOTHR_400: s_d.xoAmpFlag = !xoSwingAbove[0];
         ris_pkg::XOTHR_600: s_d.xoAmpFlag = !xoSwingAbove[1];
         default:            s_d.xoAmpFlag = !xoSwingAbove[2];
      endcase
      s_d.xoFreqFlag = !xoFreqInWindow && !s_q.mon[ris_pkg::M_XOFBYP];
      s_d.xoLos      = s_d.xoAmpFlag || s_d.xoFreqFlag;
      s_d.xoValid    = s_q.mon[ris_pkg::M_XOBYP] || !s_d.xoLos;

      // TCXO monitors
      case (s_q.mon[ris_pkg::M_TCEDGE +: 2])
         ris_pkg::EDGE_FALL: s_d.tcAmpFlag = !tcxoFallFast;
         ris_pkg::EDGE_BOTH: s_d.tcAmpFlag = !(tcxoRiseFast && tcxoFallFast);
         default:            s_d.tcAmpFlag = !tcxoRiseFast;
      endcase
      s_d.tcFreqFlag = !tcxoFreqInWindow && !s_q.mon[ris_pkg::M_TCFBYP];
      s_d.tcLos      = s_d.tcAmpFlag || s_d.tcFreqFlag;
      s_d.tcValid    = s_q.mon[ris_pkg::M_TCBYP] || !s_d.tcLos;

      // Validation timers
      for (int i = 0; i < 6; i++) begin
         if (refMonFlag[i]) begin
            s_d.cnt[i]   = '0;
            s_d.valid[i] = 1'b0;
         end else if (s_q.cnt[i] >= s_q.vtim[ris_pkg::VTIM_W-1:0]) begin
            s_d.valid[i] = 1'b1;
         end else begin
            s_d.cnt[i] = s_q.cnt[i] + 16'h0001;
         end
      end

      // Channel selection
      for (int c = 0; c < 2; c++) begin
         manOk    = (manIdx[c] < 3'h6) && inOk(s_q.valid & chMask[c], manIdx[c]);
         curOk    = (s_q.ch[c].mode == ris_pkg::RIS_LOCKED)
                    && inOk(s_q.valid & chMask[c], s_q.ch[c].sel);
         tgtFound = 1'b0;
         tgt      = s_q.ch[c].sel;
         case (chMode[c])
            ris_pkg::MODE_AUTO_REV: begin
               tgtFound = best[c].found;
               tgt      = best[c].idx;
            end
            ris_pkg::MODE_AUTO_NREV: begin
               if (curOk) begin
                  tgtFound = 1'b1;
               end else begin
                  tgtFound = best[c].found;
                  tgt      = best[c].idx;
               end
            end
            ris_pkg::MODE_MAN_FB: begin
               if (manOk) begin
                  tgtFound = 1'b1;
                  tgt      = manIdx[c];
               end else begin
                  tgtFound = best[c].found;
                  tgt      = best[c].idx;
               end
            end
            default: begin
               tgtFound = manOk;
               tgt      = manIdx[c];
            end
         endcase
         s_d.ch[c].switched    = tgtFound && (s_q.ch[c].mode == ris_pkg::RIS_LOCKED)
                                 && (tgt != s_q.ch[c].sel);
         s_d.ch[c].hitlessStep = s_d.ch[c].switched
                                 && s_q.ctrl[c*ris_pkg::CH_STRIDE+ris_pkg::F_HITLESS];
         if (tgtFound) begin
            s_d.ch[c].sel  = tgt;
            s_d.ch[c].mode = ris_pkg::RIS_LOCKED;
         end else if (historyValid[c]) begin
            s_d.ch[c].mode = ris_pkg::RIS_HOLDOVER;
         end else begin
            s_d.ch[c].mode = ris_pkg::RIS_FREERUN;
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q            <= '0;
         s_q.ctrl       <= ris_pkg::CTRL_RST;
         s_q.prio1      <= ris_pkg::PRIO_RST;
         s_q.prio2      <= ris_pkg::PRIO_RST;
         s_q.mon        <= ris_pkg::MON_RST;
         s_q.vtim       <= ris_pkg::VTIM_RST;
         s_q.ch[0].mode <= ris_pkg::RIS_FREERUN;
         s_q.ch[1].mode <= ris_pkg::RIS_FREERUN;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign s_axi_awready      = s_q.awready;
   assign s_axi_wready       = s_q.wready;
   assign s_axi_bvalid       = s_q.bvalid;
   assign s_axi_bresp        = s_q.bresp;
   assign s_axi_arready      = s_q.arready;
   assign s_axi_rvalid       = s_q.rvalid;
   assign s_axi_rdata        = s_q.rdata;
   assign s_axi_rresp        = s_q.rresp;
   assign ch1Status          = s_q.ch[0];
   assign ch2Status          = s_q.ch[1];
   assign xoSignalLossFlag   = s_q.xoLos;
   assign tcxoSignalLossFlag = s_q.tcLos;
   assign xoValid            = s_q.xoValid;
   assign tcxoValid          = s_q.tcValid;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence flagThenQuiet0;
      refMonFlag[0] ##1 (!refMonFlag[0] && s_q.vtim[15:0] == 16'h0000);
   endsequence

   valid_after_quiet_a: assert property (
      flagThenQuiet0 |=> s_q.valid[0]
   ) else $error("input 0 not valid after quiet interval");

   flag_kills_valid_a: assert property (
      refMonFlag[0] |=> !s_q.valid[0] && s_q.cnt[0] == 16'h0000
   ) else $error("flag did not disqualify input 0");

   revert_best_a: assert property (
      chMode[0] == ris_pkg::MODE_AUTO_REV && best[0].found
      |=> s_q.ch[0].sel == $past(best[0].idx) && s_q.ch[0].mode == ris_pkg::RIS_LOCKED
   ) else $error("revertive channel 1 missed best input");

   nonrev_keep_a: assert property (
      chMode[0] == ris_pkg::MODE_AUTO_NREV && s_q.ch[0].mode == ris_pkg::RIS_LOCKED
      && inOk(s_q.valid & chMask[0], s_q.ch[0].sel) |=> $stable(s_q.ch[0].sel)
   ) else $error("non-revertive channel 1 switched a valid input");

   fallback_man_a: assert property (
      chMode[1] == ris_pkg::MODE_MAN_FB && manIdx[1] < 3'h6
      && inOk(s_q.valid & chMask[1], manIdx[1]) |=> s_q.ch[1].sel == $past(manIdx[1])
   ) else $error("fallback channel 2 left valid manual input");

   man_holdover_a: assert property (
      chMode[0] == ris_pkg::MODE_MAN_HO && !inOk(s_q.valid & chMask[0], manIdx[0])
      |=> s_q.ch[0].mode != ris_pkg::RIS_LOCKED
   ) else $error("manual holdover channel 1 tried another input");

   holdover_hist_a: assert property (
      s_q.ch[1].mode == ris_pkg::RIS_HOLDOVER |-> $past(historyValid[1])
   ) else $error("channel 2 in holdover without history");

   xo_loss_or_a: assert property (
      !xoSwingAbove[0] |=> xoSignalLossFlag
   ) else $error("XO loss pin missed amplitude flag");

   xo_bypass_a: assert property (
      s_q.mon[ris_pkg::M_XOBYP] |=> xoValid
   ) else $error("XO bypass did not force valid");

   tc_bypass_a: assert property (
      s_q.mon[ris_pkg::M_TCBYP] |=> tcxoValid
   ) else $error("TCXO bypass did not force valid");

   hitless_gate_a: assert property (
      s_q.ch[0].hitlessStep |-> s_q.ch[0].switched
      && $past(s_q.ctrl[ris_pkg::F_HITLESS])
   ) else $error("hitless step without enabled switchover");

endmodule : ris_reference_input_selector

// file: test/ris_ref_source_model.sv
// Purpose: Reference source health and selection pin model
// Assumes: Bench sets health and pin requests
// Notes:   Outputs change only at rising edges
`timescale 1ns/1ns
module ris_ref_source_model (
   input  wire logic       ref_clk,
   input  wire logic [5:0] deadSrc,
   input  wire logic [1:0] pinReq,
   output logic [5:0]      refMonFlag,
   output logic [1:0][1:0] inputChoicePins
);
   initial begin
      refMonFlag = 6'h00;
      inputChoicePins = 4'h0;
   end
   always @(posedge ref_clk) begin
      refMonFlag <= deadSrc;
      inputChoicePins <= {2'h0, pinReq};
   end
endmodule : ris_ref_source_model

// file: test/reference_input_selector_tb_top.sv
// Purpose: Self-checking bench for the reference input selector
// Assumes: AXI4-Lite access, validation count left at zero
// Notes:   Channel 1 exercised, channel 2 in manual fallback late in the run
`timescale 1ns/1ns
module reference_input_selector_tb_top;
   logic                 ref_clk = 1'b0, rst_n = 1'b0, freqOk = 1'b1;
   logic [7:0]           aw = 8'h00, ar = 8'h00;
   logic [31:0]          wd = 32'h0000_0000, rdata, d;
   logic                 awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
   logic                 awRdy, wRdy, bVld, arRdy, rVld, xoLoss, xoOk;
   logic [1:0]           bresp, rresp, r, hist = 2'h0, pinReq = 2'h0;
   logic [2:0]           swing = 3'h1;
   logic [5:0]           dead = 6'h00, monFlag;
   logic [1:0][1:0]      pins;
   logic                 rise = 1'b1, fall = 1'b1, tcFreq = 1'b1, tcLoss, tcOk, hitSeen = 1'b0;
   ris_pkg::ris_chstat_t st1, st2;
   int                   fail_count = 0, total_checks = 0;
   int                   codes[5] = '{0, 1, 2, 3, 5};

   ris_ref_source_model i_ris_ref_source_model (.ref_clk(ref_clk), .deadSrc(dead),
      .pinReq(pinReq), .refMonFlag(monFlag), .inputChoicePins(pins));
   ris_reference_input_selector i_ris_reference_input_selector (.ref_clk(ref_clk),
      .rst_n(rst_n), .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awRdy),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wRdy),
      .s_axi_bresp(bresp), .s_axi_bvalid(bVld), .s_axi_bready(brdy), .s_axi_araddr(ar),
      .s_axi_arvalid(arv), .s_axi_arready(arRdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rVld), .s_axi_rready(rrdy), .refMonFlag(monFlag),
      .inputChoicePins(pins), .historyValid(hist), .xoSwingAbove(swing),
      .xoFreqInWindow(freqOk), .tcxoRiseFast(rise), .tcxoFallFast(fall),
      .tcxoFreqInWindow(tcFreq), .ch1Status(st1), .ch2Status(st2),
      .xoSignalLossFlag(xoLoss), .tcxoSignalLossFlag(tcLoss), .xoValid(xoOk), .tcxoValid(tcOk));

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      @(posedge ref_clk);
      aw <= a;
      wd <= v;
      awv <= 1'b1;
      wv <= 1'b1;
      brdy <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (awRdy) awv <= 1'b0;
         if (wRdy) wv <= 1'b0;
      end while (!bVld);
      rs = bresp;
      brdy <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge ref_clk);
      ar <= a;
      arv <= 1'b1;
      rrdy <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (arRdy) arv <= 1'b0;
      end while (!rVld);
      v = rdata;
      rs = rresp;
      rrdy <= 1'b0;
   endtask : rd
   task automatic ex(input logic [2:0] s, input logic [2:0] m);
      repeat (8) @(posedge ref_clk);
      chk("sel", 32'(st1.sel), 32'(s));
      chk("mode", 32'(st1.mode), 32'(m));
   endtask : ex
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : stop_test

   initial forever #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (st1.hitlessStep) hitSeen <= 1'b1;
   end
   initial begin
      repeat (4000) @(posedge ref_clk);
      fail_count++;
      stop_test();
   end
   initial begin
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(8'h18, d, r);
      chk("unmapped", {d[29:0], r}, 32'h0000_0002);
      wr(ris_pkg::STAT_OFS, 32'h0000_0000, r);
      chk("readonly", 32'(r), 32'h0000_0002);
      wr(ris_pkg::PRIO1_OFS, 32'h0000_0288, r);
      ex(3'h1, 3'h1);
      dead <= 6'h02;
      ex(3'h3, 3'h1);
      dead <= 6'h00;
      ex(3'h1, 3'h1);
      rd(ris_pkg::STAT_OFS, d, r);
      chk("status", 32'(d[2:0]), 32'h0000_0001);
      wr(ris_pkg::CTRL_OFS, 32'h0000_0001, r);
      dead <= 6'h02;
      ex(3'h3, 3'h1);
      dead <= 6'h00;
      ex(3'h3, 3'h1);
      $display("test automatic done");
      foreach (codes[i]) begin
         wr(ris_pkg::CTRL_OFS, 32'(3 + 8 * codes[i]), r);
         ex(3'(codes[i]), 3'h1);
      end
      dead <= 6'h20;
      ex(3'h5, 3'h4);
      dead <= 6'h00;
      ex(3'h5, 3'h1);
      hist <= 2'h1;
      dead <= 6'h20;
      ex(3'h5, 3'h2);
      dead <= 6'h00;
      chk("hitless", 32'(hitSeen), 32'h0000_0000);
      wr(ris_pkg::CTRL_OFS, 32'h0000_2246, r);
      for (int p = 0; p < 4; p++) begin
         pinReq <= 2'(p);
         ex(3'(p), 3'h1);
      end
      chk("hitless", 32'(hitSeen), 32'h0000_0001);
      chk("sel2", 32'(st2.sel), 32'h0000_0004);
      hist <= 2'h3;
      dead <= 6'h18;
      ex(3'h1, 3'h1);
      chk("mode2", 32'(st2.mode), 32'h0000_0002);
      $display("test manual done");
      for (int t = 0; t < 3; t++) begin
         wr(ris_pkg::MON_OFS, 32'(t), r);
         repeat (6) @(posedge ref_clk);
         chk("xoLoss", 32'(xoLoss), 32'(t != 0));
      end
      freqOk <= 1'b0;
      wr(ris_pkg::MON_OFS, 32'h0000_0000, r);
      repeat (6) @(posedge ref_clk);
      chk("xoLoss", 32'(xoLoss), 32'h0000_0001);
      wr(ris_pkg::MON_OFS, 32'h0000_0004, r);
      repeat (6) @(posedge ref_clk);
      chk("xoLoss", 32'(xoLoss), 32'h0000_0000);
      swing <= 3'h0;
      wr(ris_pkg::MON_OFS, 32'h0000_0008, r);
      repeat (6) @(posedge ref_clk);
      chk("xoValid", 32'(xoOk), 32'h0000_0001);
      $display("test oscillator done");
      rise <= 1'b0;
      for (int e = 1; e < 4; e++) begin
         wr(ris_pkg::MON_OFS, 32'(16 * e), r);
         repeat (6) @(posedge ref_clk);
         chk("tcLoss", 32'(tcLoss), 32'(e != 2));
      end
      tcFreq <= 1'b0;
      wr(ris_pkg::MON_OFS, 32'h0000_0020, r);
      repeat (6) @(posedge ref_clk);
      chk("tcLoss", 32'(tcLoss), 32'h0000_0001);
      wr(ris_pkg::MON_OFS, 32'h0000_0060, r);
      repeat (6) @(posedge ref_clk);
      chk("tcLoss", 32'(tcLoss), 32'h0000_0000);
      wr(ris_pkg::MON_OFS, 32'h0000_0080, r);
      repeat (6) @(posedge ref_clk);
      chk("tcValid", 32'(tcOk), 32'h0000_0001);
      $display("test tcxo done");
      stop_test();
   end
endmodule : reference_input_selector_tb_top
